// *** include/cms_pkg.sv ***
// Purpose: shared constants for the cache RAM self-test port and its controller
// Assumes: single clock, 64-bit test buses, 256-bit data RAM row
// Notes: cache size is coded 0..4 for 128KB..2MB
package cms_pkg;
  localparam int ADDR_W = 18;
  localparam int DIN_W = 64;
  localparam int ROW_W = 256;
  localparam int LANE_W = 32;
  localparam int CE_W = 11;
  localparam int DCTL_W = 13;
  localparam int INDEX_W = 16;
  localparam int DWORDS = ROW_W / DIN_W;
  localparam int CE_DATA_BIT = 0;
  localparam int DCTL_DATA_BIT = 2;
  localparam int DCTL_OTHER_LO = 3;
  localparam int DCTL_OTHER_HI = 12;
  localparam int DSEL_LO = 0;
  localparam int DSEL_HI = 1;
  localparam int HI_ADDR_LO = 15;
  localparam int LO_ADDR_LO = 2;
  localparam logic [2:0] SIZE_128K = 3'h0;
  localparam logic [2:0] SIZE_2M = 3'h4;
  localparam logic [3:0] SLOWEST_LATENCY = 4'h7;
  localparam logic [3:0] TEST_LATENCY = 4'h0;
  localparam logic [LANE_W-1:0] LANE_DW0 = 32'h0000000F;
  localparam int READ_STAGES = 2;
endpackage

// *** include/cms_if.sv ***
// Purpose: self-test port wires between the cache and the test controller
// Assumes: one clock, all signals synchronous
// Notes: no clocking block; the bench joins the two ends here
`timescale 1ns/1ns
interface cms_if;
  logic selftest_mode_select;
  logic [cms_pkg::ADDR_W-1:0] selftest_address_bus;
  logic [cms_pkg::DIN_W-1:0] selftest_write_bus;
  logic [cms_pkg::DIN_W-1:0] selftest_read_bus;
  logic [cms_pkg::CE_W-1:0] selftest_ram_enables;
  logic selftest_write_en;
  logic [cms_pkg::DCTL_W-1:0] selftest_read_select;
  modport device (
    input selftest_mode_select,
    input selftest_address_bus,
    input selftest_write_bus,
    input selftest_ram_enables,
    input selftest_write_en,
    input selftest_read_select,
    output selftest_read_bus
  );
  modport tester (
    output selftest_mode_select,
    output selftest_address_bus,
    output selftest_write_bus,
    output selftest_ram_enables,
    output selftest_write_en,
    output selftest_read_select,
    input selftest_read_bus
  );
endinterface

// *** core/cms_cache_port.sv ***
// Purpose: cache-side self-test port steering the data RAM during test mode
// Assumes: clk_sys 10 MHz, reset_n asynchronous active low, inputs synchronous
// Notes: the data RAM itself sits outside; its read word returns unregistered
`timescale 1ns/1ns
module cms_cache_port #(
  parameter logic [2:0] CACHE_SIZE = cms_pkg::SIZE_128K
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  cms_if.device tp,
  input wire logic func_ram_enable,
  input wire logic func_ram_write,
  input wire logic [cms_pkg::INDEX_W-1:0] func_ram_index,
  input wire logic [cms_pkg::ROW_W-1:0] func_ram_write_word,
  input wire logic [cms_pkg::LANE_W-1:0] func_ram_lane_enables,
  input wire logic latency_cfg_write,
  input wire logic [3:0] latency_cfg_value,
  input wire logic [cms_pkg::ROW_W-1:0] data_ram_read_word,
  output logic data_ram_chip_enable,
  output logic data_ram_write_enable,
  output logic [cms_pkg::INDEX_W-1:0] data_ram_index,
  output logic [cms_pkg::ROW_W-1:0] data_ram_write_word,
  output logic [cms_pkg::LANE_W-1:0] data_ram_lane_enables,
  output logic [3:0] ram_latency,
  output logic test_active
);
  logic mode_r;
  logic [cms_pkg::ADDR_W-1:0] addr_r;
  logic [cms_pkg::DIN_W-1:0] din_r;
  logic ce_r;
  logic we_r;
  logic [cms_pkg::DCTL_W-1:0] dctl_r;
  logic [3:0] lat_cfg_r;
  logic [cms_pkg::ROW_W-1:0] second_line_read_buffer;
  logic [1:0] dsel_r;
  logic [cms_pkg::DIN_W-1:0] dout_r;
  logic [cms_pkg::INDEX_W-1:0] t_index;
  logic [cms_pkg::LANE_W-1:0] t_lanes;
  logic capture;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= 1'b0;
      addr_r <= '0;
      din_r <= '0;
      ce_r <= 1'b0;
      we_r <= 1'b0;
      dctl_r <= '0;
    end else begin
      mode_r <= tp.selftest_mode_select;
      addr_r <= tp.selftest_address_bus;
      din_r <= tp.selftest_write_bus;
      ce_r <= tp.selftest_ram_enables[cms_pkg::CE_DATA_BIT];
      we_r <= tp.selftest_write_en;
      dctl_r <= tp.selftest_read_select;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lat_cfg_r <= cms_pkg::SLOWEST_LATENCY;
    end else if (latency_cfg_write) begin
      lat_cfg_r <= latency_cfg_value;
    end
  end

  always_comb begin
    t_index = '0;
    case (CACHE_SIZE)
      3'h0: t_index = {4'h0, addr_r[17:15], addr_r[10:2]};
      3'h1: t_index = {3'h0, addr_r[17:15], addr_r[11:2]};
      3'h2: t_index = {2'h0, addr_r[17:15], addr_r[12:2]};
      3'h3: t_index = {1'h0, addr_r[17:15], addr_r[13:2]};
      default: t_index = addr_r[17:2];
    endcase
  end

  assign t_lanes = cms_pkg::LANE_DW0 << {addr_r[cms_pkg::DSEL_HI:cms_pkg::DSEL_LO], 2'h0};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_ram_chip_enable <= 1'b0;
      data_ram_write_enable <= 1'b0;
      data_ram_index <= '0;
      data_ram_write_word <= '0;
      data_ram_lane_enables <= '0;
    end else if (mode_r) begin
      data_ram_chip_enable <= ce_r;
      data_ram_write_enable <= ce_r & we_r;
      data_ram_index <= t_index;
      // 64-bit word replicated on all lanes
      data_ram_write_word <= {cms_pkg::DWORDS{din_r}};
      data_ram_lane_enables <= t_lanes;
    end else begin
      data_ram_chip_enable <= func_ram_enable;
      data_ram_write_enable <= func_ram_write;
      data_ram_index <= func_ram_index;
      data_ram_write_word <= func_ram_write_word;
      data_ram_lane_enables <= func_ram_lane_enables;
    end
  end

  assign ram_latency = mode_r ? cms_pkg::TEST_LATENCY : lat_cfg_r;
  assign test_active = mode_r;

  assign capture = mode_r & dctl_r[cms_pkg::DCTL_DATA_BIT]
    & ~|dctl_r[cms_pkg::DCTL_OTHER_HI:cms_pkg::DCTL_OTHER_LO];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      second_line_read_buffer <= '0;
      dsel_r <= 2'h0;
    end else if (capture) begin
      second_line_read_buffer <= data_ram_read_word;
      dsel_r <= dctl_r[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dout_r <= '0;
    end else begin
      dout_r <= second_line_read_buffer[dsel_r*cms_pkg::DIN_W +: cms_pkg::DIN_W];
    end
  end

  assign tp.selftest_read_bus = dout_r;
endmodule // cms_cache_port

// *** core/cms_tester.sv ***
// Purpose: test controller end driving the self-test port from simple commands
// Assumes: clk_sys 10 MHz, reset_n asynchronous active low
// Notes: one command at a time; read data returns after the wait plus two stages
`timescale 1ns/1ns
module cms_tester #(
  parameter int RAM_LATENCY = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  cms_if.tester tp,
  input wire logic test_enable,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [cms_pkg::ADDR_W-1:0] cmd_address,
  input wire logic [cms_pkg::DIN_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [cms_pkg::DIN_W-1:0] rsp_data
);
  typedef enum logic [1:0] {CMS_IDLE, CMS_WAIT, CMS_CAPT, CMS_RET} cms_state_t;
  cms_state_t state_r;
  logic [3:0] cnt_r;
  logic [1:0] dsel_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tp.selftest_mode_select <= 1'b0;
    end else begin
      tp.selftest_mode_select <= test_enable;
    end
  end

  assign cmd_ready = (state_r == CMS_IDLE) & test_enable;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CMS_IDLE;
      cnt_r <= 4'h0;
      dsel_r <= 2'h0;
      tp.selftest_address_bus <= '0;
      tp.selftest_write_bus <= '0;
      tp.selftest_ram_enables <= '0;
      tp.selftest_write_en <= 1'b0;
      tp.selftest_read_select <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      tp.selftest_ram_enables <= '0;
      tp.selftest_write_en <= 1'b0;
      tp.selftest_read_select <= '0;
      rsp_valid <= 1'b0;
      case (state_r)
        CMS_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            tp.selftest_address_bus <= cmd_address;
            tp.selftest_write_bus <= cmd_data;
            tp.selftest_ram_enables[cms_pkg::CE_DATA_BIT] <= 1'b1;
            tp.selftest_write_en <= cmd_write;
            dsel_r <= cmd_address[1:0];
            // wait states for latency
            // one edge for the port output register, then the RAM's own latency
            cnt_r <= 4'(RAM_LATENCY + 1);
            state_r <= cmd_write ? CMS_IDLE : CMS_WAIT;
          end
        end
        CMS_WAIT: begin
          if (cnt_r <= 4'h1) begin
            tp.selftest_read_select <= {10'h000, 1'b1, dsel_r};
            cnt_r <= 4'(cms_pkg::READ_STAGES + 2);
            state_r <= CMS_CAPT;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        CMS_CAPT: begin
          if (cnt_r <= 4'h1) begin
            state_r <= CMS_RET;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        CMS_RET: begin
          rsp_valid <= 1'b1;
          rsp_data <= tp.selftest_read_bus;
          state_r <= CMS_IDLE;
        end
        default: state_r <= CMS_IDLE;
      endcase
    end
  end
  // full sweep is the command source's job
endmodule // cms_tester

// *** tb/cms_asserts.sv ***
// Purpose: self-test port wire checks
// Assumes: one clock, data RAM tests only
// Notes: watches the interface wires only
`timescale 1ns/1ns
module cms_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic selftest_mode_select,
  input wire logic [cms_pkg::ADDR_W-1:0] selftest_address_bus,
  input wire logic [cms_pkg::DIN_W-1:0] selftest_write_bus,
  input wire logic [cms_pkg::DIN_W-1:0] selftest_read_bus,
  input wire logic [cms_pkg::CE_W-1:0] selftest_ram_enables,
  input wire logic selftest_write_en,
  input wire logic [cms_pkg::DCTL_W-1:0] selftest_read_select
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  one_ram_a: assert property ($onehot0(selftest_ram_enables))
    else $error("two RAMs enabled");
  data_ce_a: assert property (selftest_ram_enables[10:1] == 10'h000)
    else $error("non-data RAM enabled");
  write_ce_a: assert property (selftest_write_en |-> selftest_ram_enables[0])
    else $error("write without data RAM enable");
  capture_sel_a: assert property (selftest_read_select[2] |->
    selftest_read_select[12:3] == 10'h000) else $error("other select bits high");
  mode_first_a: assert property (selftest_ram_enables != 11'h000 |->
    selftest_mode_select) else $error("enable outside test mode");
  idle_hold_a: assert property (!selftest_mode_select [*5] |->
    $stable(selftest_read_bus)) else $error("read bus moved outside test mode");
  read_lat_a: assert property ($changed(selftest_read_bus) |->
    $past(selftest_read_select[2], 3)) else $error("read bus not two stages after capture");
  capture_win_a: assert property (selftest_ram_enables[0] && !selftest_write_en |->
    ##[2:12] selftest_read_select[2]) else $error("no capture after read");
  cover property (selftest_write_en);
  cover property (selftest_read_select[2]);
  cover property ($changed(selftest_read_bus));
endmodule // cms_asserts

// *** tb/test_cache_ram_mbist_port.sv ***
// Purpose: bench joining the cache port and the tester
// Assumes: 10 MHz clk_sys, one-cycle data RAM modelled here
// Notes: RAM output toggles when not read
`timescale 1ns/1ns
module test_cache_ram_mbist_port;
  logic clk_sys, reset_n, test_enable, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic f_en, f_wr, lat_wr, ce_o, we_o, act_o;
  logic [17:0] cmd_address;
  logic [63:0] cmd_data, rsp_data;
  logic [15:0] f_idx, idx_o;
  logic [255:0] f_word, rd_word, wd_o;
  logic [31:0] f_ln, ln_o;
  logic [3:0] lat_val, lat_o;
  logic [255:0] mem [int];
  logic [31:0] lnq[$];
  logic [15:0] ixq[$];
  int errors, cmp_count, cycles;
  cms_if cms_if_inst ();
  cms_cache_port cms_cache_port_inst (.clk_sys(clk_sys), .reset_n(reset_n), .tp(cms_if_inst),
    .func_ram_enable(f_en), .func_ram_write(f_wr), .func_ram_index(f_idx),
    .func_ram_write_word(f_word), .func_ram_lane_enables(f_ln), .latency_cfg_write(lat_wr),
    .latency_cfg_value(lat_val), .data_ram_read_word(rd_word), .data_ram_chip_enable(ce_o),
    .data_ram_write_enable(we_o), .data_ram_index(idx_o), .data_ram_write_word(wd_o),
    .data_ram_lane_enables(ln_o), .ram_latency(lat_o), .test_active(act_o));
  cms_tester #(.RAM_LATENCY(1)) cms_tester_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .tp(cms_if_inst), .test_enable(test_enable), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_address(cmd_address), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  cms_asserts cms_asserts_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .selftest_mode_select(cms_if_inst.selftest_mode_select),
    .selftest_address_bus(cms_if_inst.selftest_address_bus),
    .selftest_write_bus(cms_if_inst.selftest_write_bus),
    .selftest_read_bus(cms_if_inst.selftest_read_bus),
    .selftest_ram_enables(cms_if_inst.selftest_ram_enables),
    .selftest_write_en(cms_if_inst.selftest_write_en),
    .selftest_read_select(cms_if_inst.selftest_read_select));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // data RAM model: each lane enable covers 16 bits, so four enables make one doubleword
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
    if (ce_o === 1'b1 && we_o === 1'b1) begin
      lnq.push_back(ln_o);
      ixq.push_back(idx_o);
      for (int i = 0; i < 16; i++)
        if (ln_o[i]) mem[idx_o][16*i +: 16] = wd_o[16*i +: 16];
    end
    rd_word <= (ce_o === 1'b1 && we_o === 1'b0) ? mem[idx_o] : ~rd_word;
  end
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // hold the command until the edge that takes it
  task automatic send(input logic w, input logic [17:0] a, input logic [63:0] d);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_address = a;
    cmd_data = d;
    while (cmd_ready !== 1'b1) tick(1);
    tick(1);
  endtask
  function automatic logic [63:0] dat(input logic [17:0] b, input int i);
    return {b, ~b, 26'h0, i[1:0]};
  endfunction
  task automatic t_latency();
    chk(lat_o, cms_pkg::SLOWEST_LATENCY);
    lat_val = 4'h3;
    lat_wr = 1'b1;
    tick(1);
    lat_wr = 1'b0;
    tick(2);
    chk(lat_o, 4'h3);
    $display("latency test done");
  endtask
  task automatic t_func();
    f_en = 1'b1;
    f_wr = 1'b1;
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    tick(1);
    f_en = 1'b0;
    tick(4);
    chk(cmd_ready, 1'b0);
    cmd_valid = 1'b0;
    chk(lnq.size(), 1);
    chk(mem[16'h0ABC], f_word);
    $display("functional test done");
  endtask
  task automatic t_mode();
    test_enable = 1'b1;
    tick(4);
    chk(act_o, 1'b1);
    chk(lat_o, cms_pkg::TEST_LATENCY);
    f_en = 1'b1;
    $display("mode test done");
  endtask
  // four doublewords of one index, while a functional write is held
  task automatic t_rw(input logic [17:0] b);
    lnq.delete();
    ixq.delete();
    for (int i = 0; i < 4; i++) send(1'b1, {b[17:2], i[1:0]}, dat(b, i));
    cmd_valid = 1'b0;
    tick(6);
    chk(lnq.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk(lnq[i], cms_pkg::LANE_DW0 << (4 * i));
      chk(ixq[i], {4'h0, b[17:15], b[10:2]});
    end
    for (int i = 3; i >= 0; i--) begin
      send(1'b0, {b[17:2], i[1:0]}, 64'h0);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1) tick(1);
      chk(rsp_data, dat(b, i));
    end
    $display("write read test done");
  endtask
  task automatic t_exit();
    f_en = 1'b0;
    test_enable = 1'b0;
    tick(4);
    chk(act_o, 1'b0);
    chk(lat_o, 4'h3);
    $display("exit test done");
  endtask
  initial begin
    {reset_n, test_enable, cmd_valid, cmd_write, f_en, f_wr, lat_wr} = 7'h00;
    {cmd_address, cmd_data, lat_val, errors, cmp_count, cycles} = '0;
    {rd_word, f_idx, f_ln, f_word} = {256'h0, 16'h0ABC, 32'hFFFFFFFF, {8{32'hA5C3F00F}}};
    tick(16);
    reset_n = 1'b1;
    tick(2);
    t_latency();
    t_func();
    t_mode();
    t_rw(18'h3FFFC);
    t_rw(18'h07804);
    t_exit();
    end_of_test();
  end
endmodule // test_cache_ram_mbist_port
